// file: logic/prt_defines.vh
// Purpose: shared constants for the per-port rate limit and cable test register slice
// Assumes: 8-bit register data, 8-bit register addresses
// Notes: included by its bare name from every design file
`ifndef PRT_DEFINES_VH
`define PRT_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PRT_OFS_P1_RATE 8'h19
`define PRT_OFS_P1_SPEC 8'h1A
`define PRT_OFS_P1_CNTL 8'h1B
`define PRT_OFS_P2_RATE 8'h29
`define PRT_OFS_P2_SPEC 8'h2A
`define PRT_OFS_P2_CNTL 8'h2B
`define PRT_OFS_P3_RATE 8'h39

// ----------------------------------------------------------------
// field positions in the special control/status register and the rate register
// ----------------------------------------------------------------
`define PRT_BIT_SHORT 7
`define PRT_RES_HI 6
`define PRT_RES_LO 5
`define PRT_BIT_START 4
`define PRT_BIT_FORCE 3
`define PRT_BIT_LOOP 1
`define PRT_BIT_CNT8 0
`define PRT_RATE_HI 6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PRT_RST_RATE 7'h00
`define PRT_RST_RES 2'h0
`define PRT_RST_CNT 9'h000
`define PRT_RD_ZERO 8'h00

// ----------------------------------------------------------------
// rate code encoding
// ----------------------------------------------------------------
`define PRT_CODE_FULL100 7'h64
`define PRT_CODE_MAX100 7'h63
`define PRT_CODE_SUB_LO 7'h65
`define PRT_CODE_SUB_HI 7'h73
`define PRT_CODE_FULL10 7'h0A
`define PRT_CODE_MAX10 7'h09
`define PRT_KBPS_PER_MBPS 17'h003E8
`define PRT_KBPS_SUB_STEP 17'h00040
`define PRT_SUB_BASE 17'h00064

// ----------------------------------------------------------------
// limit mode encoding
// ----------------------------------------------------------------
`define PRT_LM_ALL 2'h0
`define PRT_LM_BMF 2'h1
`define PRT_LM_BM 2'h2
`define PRT_LM_B 2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PRT_CLK_PERIOD_NS 40
`define PRT_TICK_NS 1000000
`define PRT_TICK_CYC (`PRT_TICK_NS / `PRT_CLK_PERIOD_NS)
`define PRT_BITS_PER_BYTE 20'h00008
`define PRT_BUCKET_CAP 20'h186A0

`endif

// file: logic/prt_rate_shaper.v
// Purpose: one ingress shaper for priority 3 traffic of a single port
// Assumes: i_tick is a one-cycle pulse once per millisecond
// Notes: credit is kept in bits; one accepted counted byte costs eight bits
`timescale 1ns/1ps
`include "prt_defines.vh"

module prt_rate_shaper #(
   parameter CW = 20
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_tick,
   input wire [6:0] i_code,
   input wire i_speed_100,
   input wire i_byte_vld,
   input wire i_counted,
   output wire o_allow
);

   // ----------------------------------------------------------------
   // rate code decode
   // ----------------------------------------------------------------
   reg [16:0] rate_kbps;
   reg unlimited;
   wire [16:0] code_w;
   assign code_w = {10'h000, i_code};

   // codes outside the table are treated as no limit, never as a stall
   always @*
   begin
      rate_kbps = 17'h00000;
      unlimited = 1'b1;
      if (i_speed_100)
      begin
         if (i_code != 7'h00 && i_code <= `PRT_CODE_MAX100)
         begin
            unlimited = 1'b0;
            rate_kbps = code_w * `PRT_KBPS_PER_MBPS;
         end
         else if (i_code >= `PRT_CODE_SUB_LO && i_code <= `PRT_CODE_SUB_HI)
         begin
            unlimited = 1'b0;
            rate_kbps = (code_w - `PRT_SUB_BASE) * `PRT_KBPS_SUB_STEP;
         end
      end
      else if (i_code != 7'h00 && i_code <= `PRT_CODE_MAX10)
      begin
         unlimited = 1'b0;
         rate_kbps = code_w * `PRT_KBPS_PER_MBPS;
      end
   end

   // ----------------------------------------------------------------
   // credit bucket
   // ----------------------------------------------------------------
   reg [CW-1:0] credit_q;
   reg [CW-1:0] credit_d;
   reg [CW:0] sum;
   wire has_credit;
   wire consume;
   assign has_credit = (credit_q >= `PRT_BITS_PER_BYTE);
   assign consume = i_byte_vld & i_counted & ~unlimited & has_credit;
   assign o_allow = unlimited | ~i_counted | has_credit;

   // refill saturates at the cap so an idle port cannot bank unbounded bursts
   always @*
   begin
      sum = {1'b0, credit_q};
      if (i_tick)
      begin
         sum = {1'b0, credit_q} + {4'h0, rate_kbps};
      end
      if (sum > {1'b0, `PRT_BUCKET_CAP})
      begin
         sum = {1'b0, `PRT_BUCKET_CAP};
      end
      if (consume)
      begin
         sum = sum - {1'b0, `PRT_BITS_PER_BYTE};
      end
      credit_d = sum[CW-1:0];
   end

   // credit register
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         credit_q <= {CW{1'b0}};
      end
      else
      begin
         credit_q <= credit_d;
      end
   end

endmodule // prt_rate_shaper

// file: logic/prt_port_regs.v
// Purpose: per-port priority-3 rate registers and PHY special control/status for a three-port switch
// Assumes: one 25 MHz clock; PHY cable test engine answers with a done pulse and its results
// Notes: register reads return data one cycle after the read strobe
//        management access reaches only the special registers of ports 1 and 2
`timescale 1ns/1ps
`include "prt_defines.vh"

module prt_port_regs #(
   parameter TICK_CYC = `PRT_TICK_CYC,
   parameter CW = 20
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire [7:0] i_reg_addr,
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire [7:0] i_reg_wdata,
   output reg [7:0] o_reg_rdata,
   input wire i_miim_port,
   input wire i_miim_wr,
   input wire i_miim_rd,
   input wire [7:0] i_miim_wdata,
   output reg [7:0] o_miim_rdata,
   input wire [2:0] i_speed_100,
   input wire [5:0] i_limit_mode,
   input wire [2:0] i_byte_vld,
   input wire [2:0] i_frame_bcast,
   input wire [2:0] i_frame_mcast,
   input wire [2:0] i_frame_flood,
   output wire [2:0] o_accept,
   output reg [1:0] o_vct_start,
   input wire [1:0] i_vct_done,
   input wire [3:0] i_vct_result,
   input wire [1:0] i_vct_short,
   input wire [17:0] i_vct_count,
   output wire [1:0] o_force_link,
   output wire [1:0] o_remote_loopback
);

   // ----------------------------------------------------------------
   // millisecond tick divider
   // ----------------------------------------------------------------
   // the divider is 16 bits wide, so TICK_CYC must stay at or below 65536
   localparam [31:0] TICK_LAST_W = TICK_CYC - 1;
   localparam [15:0] TICK_LAST = TICK_LAST_W[15:0];
   reg [15:0] tick_cnt_q;
   reg tick_q;

   // one enable pulse per millisecond refills every shaper
   // tick_q is high for exactly one cycle per period
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         tick_cnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end
      else if (tick_cnt_q == TICK_LAST)
      begin
         tick_cnt_q <= 16'h0000;
         tick_q <= 1'b1;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // one write strobe per storage group; reads are decoded in the read mux
   wire wr_rate1;
   wire wr_rate2;
   wire wr_rate3;
   wire [1:0] sw_wr_spec;
   wire [1:0] mi_wr_spec;
   wire [1:0] wr_spec;
   wire [7:0] spec_wdata0;
   wire [7:0] spec_wdata1;

   // rate registers are reached from the switch bus only
   assign wr_rate1 = i_reg_wr & (i_reg_addr == `PRT_OFS_P1_RATE);
   assign wr_rate2 = i_reg_wr & (i_reg_addr == `PRT_OFS_P2_RATE);
   assign wr_rate3 = i_reg_wr & (i_reg_addr == `PRT_OFS_P3_RATE);
   assign sw_wr_spec[0] = i_reg_wr & (i_reg_addr == `PRT_OFS_P1_SPEC);
   assign sw_wr_spec[1] = i_reg_wr & (i_reg_addr == `PRT_OFS_P2_SPEC);
   // management writes reach the same registers; switch bus wins a same-port clash
   assign mi_wr_spec[0] = i_miim_wr & ~i_miim_port;
   assign mi_wr_spec[1] = i_miim_wr & i_miim_port;
   assign wr_spec = sw_wr_spec | mi_wr_spec;
   assign spec_wdata0 = sw_wr_spec[0] ? i_reg_wdata : i_miim_wdata;
   assign spec_wdata1 = sw_wr_spec[1] ? i_reg_wdata : i_miim_wdata;

   // ----------------------------------------------------------------
   // priority-3 rate registers
   // ----------------------------------------------------------------
   reg [6:0] rate1_q;
   reg [6:0] rate2_q;
   reg [6:0] rate3_q;

   // only bits 6-0 are stored; bit 7 has no storage and reads zero
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rate1_q <= `PRT_RST_RATE;
         rate2_q <= `PRT_RST_RATE;
         rate3_q <= `PRT_RST_RATE;
      end
      else
      begin
         if (wr_rate1)
         begin
            rate1_q <= i_reg_wdata[`PRT_RATE_HI:0];
         end
         if (wr_rate2)
         begin
            rate2_q <= i_reg_wdata[`PRT_RATE_HI:0];
         end
         if (wr_rate3)
         begin
            rate3_q <= i_reg_wdata[`PRT_RATE_HI:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // special control bits and cable test, ports 1 and 2
   // ----------------------------------------------------------------
   reg [1:0] start_q;
   reg [1:0] force_q;
   reg [1:0] loop_q;
   reg [1:0] short_q;
   reg [3:0] res_q;
   reg [17:0] cnt_q;
   wire [1:0] start_set;

   // a start written in the cycle the previous test finishes begins a new test
   assign start_set[0] = wr_spec[0] & spec_wdata0[`PRT_BIT_START];
   assign start_set[1] = wr_spec[1] & spec_wdata1[`PRT_BIT_START];

   // control bits of ports 1 and 2
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         force_q <= 2'h0;
         loop_q <= 2'h0;
      end
      else
      begin
         if (wr_spec[0])
         begin
            force_q[0] <= spec_wdata0[`PRT_BIT_FORCE];
            loop_q[0] <= spec_wdata0[`PRT_BIT_LOOP];
         end
         if (wr_spec[1])
         begin
            force_q[1] <= spec_wdata1[`PRT_BIT_FORCE];
            loop_q[1] <= spec_wdata1[`PRT_BIT_LOOP];
         end
      end
   end

   // start bit, start pulse to the test engine and captured results
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         start_q <= 2'h0;
         o_vct_start <= 2'h0;
         short_q <= 2'h0;
         res_q <= {`PRT_RST_RES, `PRT_RST_RES};
         cnt_q <= {`PRT_RST_CNT, `PRT_RST_CNT};
      end
      else
      begin
         o_vct_start <= start_set;
         // port 1: a start write wins over a done pulse in the same cycle
         if (start_set[0])
         begin
            start_q[0] <= 1'b1;
         end
         else if (i_vct_done[0] & start_q[0])
         begin
            start_q[0] <= 1'b0;
         end
         // port 2: same order; a done pulse with no test running is ignored
         if (start_set[1])
         begin
            start_q[1] <= 1'b1;
         end
         else if (i_vct_done[1] & start_q[1])
         begin
            start_q[1] <= 1'b0;
         end
         // results update together with the self-clear, so a zero start bit means valid data
         if (i_vct_done[0] & start_q[0])
         begin
            short_q[0] <= i_vct_short[0];
            res_q[1:0] <= i_vct_result[1:0];
            cnt_q[8:0] <= i_vct_count[8:0];
         end
         if (i_vct_done[1] & start_q[1])
         begin
            short_q[1] <= i_vct_short[1];
            res_q[3:2] <= i_vct_result[3:2];
            cnt_q[17:9] <= i_vct_count[17:9];
         end
      end
   end

   // ----------------------------------------------------------------
   // levels to the port PHYs
   // ----------------------------------------------------------------
   // both levels come straight from flip-flops, so the PHY never sees a glitch
   assign o_force_link = force_q;
   assign o_remote_loopback = loop_q;

   // ----------------------------------------------------------------
   // read views
   // ----------------------------------------------------------------
   wire [7:0] spec_rd0;
   wire [7:0] spec_rd1;
   reg [7:0] reg_rd_d;

   // bit 2 is reserved and reads zero
   // port 2 count sits in cnt_q[17:9], so its low byte is cnt_q[16:9]
   assign spec_rd0 = {short_q[0], res_q[1:0], start_q[0], force_q[0], 1'b0, loop_q[0], cnt_q[8]};
   assign spec_rd1 = {short_q[1], res_q[3:2], start_q[1], force_q[1], 1'b0, loop_q[1], cnt_q[17]};

   // unmapped and reserved locations, port 3 special ones included, read zero
   always @*
   begin
      reg_rd_d = `PRT_RD_ZERO;
      case (i_reg_addr)
         `PRT_OFS_P1_RATE: reg_rd_d = {1'b0, rate1_q};
         `PRT_OFS_P2_RATE: reg_rd_d = {1'b0, rate2_q};
         `PRT_OFS_P3_RATE: reg_rd_d = {1'b0, rate3_q};
         `PRT_OFS_P1_SPEC: reg_rd_d = spec_rd0;
         `PRT_OFS_P2_SPEC: reg_rd_d = spec_rd1;
         `PRT_OFS_P1_CNTL: reg_rd_d = `PRT_RD_ZERO;
         `PRT_OFS_P2_CNTL: reg_rd_d = cnt_q[16:9];
         default: reg_rd_d = `PRT_RD_ZERO;
      endcase
   end

   // read data registers hold their value until the next read
   // a read and a write in one cycle return the old value
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_reg_rdata <= `PRT_RD_ZERO;
         o_miim_rdata <= `PRT_RD_ZERO;
      end
      else
      begin
         if (i_reg_rd)
         begin
            o_reg_rdata <= reg_rd_d;
         end
         // management reads see only the special register of the chosen port
         if (i_miim_rd)
         begin
            o_miim_rdata <= i_miim_port ? spec_rd1 : spec_rd0;
         end
      end
   end

   // ----------------------------------------------------------------
   // frame classification and shapers
   // ----------------------------------------------------------------
   reg [2:0] counted;
   integer p;

   // the mode picks which frames spend credit; others pass untouched
   always @*
   begin
      counted = 3'h0;
      for (p = 0; p < 3; p = p + 1)
      begin
         case (i_limit_mode[2*p +: 2])
            `PRT_LM_ALL: counted[p] = 1'b1;
            `PRT_LM_BMF: counted[p] = i_frame_bcast[p] | i_frame_mcast[p] | i_frame_flood[p];
            `PRT_LM_BM: counted[p] = i_frame_bcast[p] | i_frame_mcast[p];
            `PRT_LM_B: counted[p] = i_frame_bcast[p];
            default: counted[p] = 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // shaper instances
   // ----------------------------------------------------------------
   // one shaper per port; all share the millisecond tick so ports stay in step
   wire [2:0] allow;
   wire [20:0] codes;
   assign codes = {rate3_q, rate2_q, rate1_q};

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_shp
         prt_rate_shaper #(
            .CW(CW)
         ) u_shp (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_tick(tick_q),
            .i_code(codes[7*g +: 7]),
            .i_speed_100(i_speed_100[g]),
            .i_byte_vld(i_byte_vld[g]),
            .i_counted(counted[g]),
            .o_allow(allow[g])
         );
      end
   endgenerate

   // qualified by the offer so an idle port never shows a stray accept
   assign o_accept = i_byte_vld & allow;

endmodule // prt_port_regs

// file: sim/prt_cable_model.sv
// Purpose: cable test engine and cable seen from the port registers
// Assumes: one start pulse per test; outcome set by the bench
// Notes: result lines toggle outside the done cycle so stale values never pass
`timescale 1ns/1ps
module prt_cable_model (
   input wire i_clk,
   input wire i_rst_n,
   input wire [1:0] i_start,
   input wire [7:0] i_lat,
   input wire [1:0] i_res,
   input wire i_short,
   input wire [8:0] i_cnt,
   output reg [1:0] o_done,
   output reg [3:0] o_result,
   output reg [1:0] o_short,
   output reg [17:0] o_count
);
   reg [7:0] wait_q [0:1];
   integer p;
   // ------------------------------------------------
   // test timing, prompt or slow as i_lat says
   // ------------------------------------------------
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_done <= 2'h0;
         o_result <= 4'h0;
         o_short <= 2'h0;
         o_count <= 18'h00000;
         wait_q[0] <= 8'h00;
         wait_q[1] <= 8'h00;
      end
      else
      begin
         o_done <= 2'h0;
         o_result <= ~o_result;
         o_short <= ~o_short;
         o_count <= ~o_count;
         for (p = 0; p < 2; p = p + 1)
         begin
            if (i_start[p])
               wait_q[p] <= i_lat;
            else if (wait_q[p] == 8'h01)
            begin
               o_done[p] <= 1'b1;
               o_result[2*p +: 2] <= i_res;
               o_short[p] <= i_short;
               o_count[9*p +: 9] <= i_cnt;
               wait_q[p] <= 8'h00;
            end
            else if (wait_q[p] != 8'h00)
               wait_q[p] <= wait_q[p] - 8'h01;
         end
      end
   end
endmodule // prt_cable_model

// file: sim/prt_port_regs_monitor.sv
// Purpose: port level checks of the rate and cable test register slice
// Assumes: bound to prt_port_regs
// Notes: one clock domain, so default clocking carries all properties
`timescale 1ns/1ps
module prt_port_regs_monitor (
   input wire i_clk,
   input wire i_rst_n,
   input wire [7:0] i_reg_addr,
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire [7:0] i_reg_wdata,
   input wire [7:0] o_reg_rdata,
   input wire i_miim_port,
   input wire i_miim_wr,
   input wire i_miim_rd,
   input wire [7:0] i_miim_wdata,
   input wire [7:0] o_miim_rdata,
   input wire [2:0] i_byte_vld,
   input wire [5:0] i_limit_mode,
   input wire [2:0] i_frame_bcast,
   input wire [2:0] o_accept,
   input wire [1:0] o_vct_start,
   input wire [1:0] o_force_link,
   input wire [1:0] o_remote_loopback
);
   // ------------------------------------------------
   // assertions
   // ------------------------------------------------
   default clocking mon_cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   start_pulse_a: assert property (i_reg_wr && i_reg_addr == 8'h2A && i_reg_wdata[4] |=> o_vct_start[1])
      else $error("no start pulse on port 2");
   start_cause_a: assert property (o_vct_start[0] |-> $past(i_reg_wr && i_reg_addr == 8'h1A && i_reg_wdata[4]
      || i_miim_wr && !i_miim_port && i_miim_wdata[4]))
      else $error("port 1 start pulse without a start write");
   loop_follow_a: assert property (i_reg_wr && i_reg_addr == 8'h1A |=> o_remote_loopback[0] == $past(i_reg_wdata[1]))
      else $error("loopback does not follow write");
   force_follow_a: assert property (i_reg_wr && i_reg_addr == 8'h2A |=> o_force_link[1] == $past(i_reg_wdata[3]))
      else $error("link force does not follow write");
   level_hold_a: assert property (!$past(i_reg_wr || i_miim_wr) |-> $stable({o_force_link, o_remote_loopback}))
      else $error("control level moved without a write");
   no_low_p1_a: assert property (i_reg_rd && i_reg_addr == 8'h1B |=> o_reg_rdata == 8'h00)
      else $error("port 1 low fault byte not zero");
   rate_top_a: assert property (i_reg_rd && i_reg_addr[3:0] == 4'h9 |=> !o_reg_rdata[7])
      else $error("rate register bit 7 not zero");
   port3_gap_a: assert property (i_reg_rd && (i_reg_addr == 8'h3A || i_reg_addr == 8'h3B) |=> o_reg_rdata == 8'h00)
      else $error("port 3 gap reads nonzero");
   mgmt_rsvd_a: assert property (i_miim_rd |=> !o_miim_rdata[2])
      else $error("management read shows reserved bit");
   uncounted_pass_a: assert property (i_byte_vld[0] && i_limit_mode[1:0] == 2'h3 && !i_frame_bcast[0]
      |-> o_accept[0])
      else $error("uncounted byte refused on port 1");
   cover property (o_vct_start[1]);
   cover property (i_miim_wr && i_miim_wdata[4]);
   cover property (i_byte_vld[0] && !o_accept[0]);
endmodule // prt_port_regs_monitor

bind prt_port_regs prt_port_regs_monitor prt_port_regs_monitor_inst (.i_clk, .i_rst_n, .i_reg_addr, .i_reg_wr,
   .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_miim_port, .i_miim_wr, .i_miim_rd, .i_miim_wdata, .o_miim_rdata,
   .i_byte_vld, .i_limit_mode, .i_frame_bcast, .o_accept, .o_vct_start, .o_force_link, .o_remote_loopback);

// file: sim/tb_top.sv
// Purpose: self-checking bench for the rate and cable test register slice
// Assumes: tick shortened to 2000 cycles so one window holds four ticks
// Notes: inputs move on the falling edge; each shaper case starts from reset
`timescale 1ns/1ps
module tb_top;
   localparam [79:0] AMAP = 80'h191A1B292A2B393A3B7F;
   reg i_clk = 1'b0;
   reg rst_n = 1'b0;
   reg [7:0] addr = 8'h00, wdata = 8'h00, mwdata = 8'h00, lat = 8'h01;
   reg wr = 1'b0, rd = 1'b0, mport = 1'b0, mwr = 1'b0, mrd = 1'b0, mshort = 1'b0;
   reg [2:0] speed = 3'h7, bvld = 3'h0, bcast = 3'h0, mcast = 3'h0, flood = 3'h0;
   reg [5:0] lmode = 6'h00;
   reg [1:0] mres = 2'h0;
   reg [8:0] mcnt = 9'h000;
   wire [7:0] rdata, mrdata;
   wire [2:0] accept;
   wire [1:0] vstart, vdone, vshort, flink, rloop;
   wire [3:0] vres;
   wire [17:0] vcount;
   integer errors = 0, check_count = 0, cyc = 0, i;
   reg [7:0] d;
   always #20 i_clk = ~i_clk;
   prt_port_regs #(.TICK_CYC(2000)) prt_port_regs_inst (.i_clk(i_clk), .i_rst_n(rst_n), .i_reg_addr(addr),
      .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_miim_port(mport),
      .i_miim_wr(mwr), .i_miim_rd(mrd), .i_miim_wdata(mwdata), .o_miim_rdata(mrdata), .i_speed_100(speed),
      .i_limit_mode(lmode), .i_byte_vld(bvld), .i_frame_bcast(bcast), .i_frame_mcast(mcast),
      .i_frame_flood(flood), .o_accept(accept), .o_vct_start(vstart), .i_vct_done(vdone), .i_vct_result(vres),
      .i_vct_short(vshort), .i_vct_count(vcount), .o_force_link(flink), .o_remote_loopback(rloop));
   prt_cable_model prt_cable_model_inst (.i_clk(i_clk), .i_rst_n(rst_n), .i_start(vstart), .i_lat(lat),
      .i_res(mres), .i_short(mshort), .i_cnt(mcnt), .o_done(vdone), .o_result(vres), .o_short(vshort),
      .o_count(vcount));
   // ------------------------------------------------
   // bench tasks
   // ------------------------------------------------
   task end_of_test;
      begin
         $display("checks %0d errors %0d", check_count, errors);
         if (errors == 0 && check_count > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task chk(input string n, input [7:0] e, input [7:0] g);
      begin
         check_count = check_count + 1;
         if (g !== e)
         begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", n, e, g);
         end
      end
   endtask
   task chk_rng(input string n, input integer lo, input integer hi, input integer g);
      begin
         check_count = check_count + 1;
         if (g < lo || g > hi)
         begin
            errors = errors + 1;
            $display("wrong value %s expected %0d..%0d seen %0d", n, lo, hi, g);
         end
      end
   endtask
   task do_reset;
      begin
         rst_n = 1'b0;
         repeat (10) @(negedge i_clk);
         rst_n = 1'b1;
      end
   endtask
   // one access on either path: m selects management, w selects write
   task acc(input m, input w, input [7:0] a, input [7:0] di, output [7:0] dr);
      begin
         @(negedge i_clk);
         addr = a;
         wdata = di;
         mwdata = di;
         mport = (a == 8'h2A);
         if (m) {mwr, mrd} = {w, !w};
         else {wr, rd} = {w, !w};
         @(negedge i_clk);
         {wr, rd, mwr, mrd} = 4'h0;
         dr = m ? mrdata : rdata;
      end
   endtask
   // results are trusted only once the start bit reads back zero
   task poll(input m, input [7:0] a, output [7:0] dr);
      integer k;
      begin
         dr = 8'h10;
         for (k = 0; k < 100 && dr[4] !== 1'b0; k = k + 1)
            acc(m, 1'b0, a, 8'h00, dr);
         chk("start bit cleared", 8'h00, dr & 8'h10);
      end
   endtask
   task shape(input [6:0] code, input s100, input [1:0] md, input bc, input integer lo, input integer hi);
      integer n, k;
      begin
         do_reset;
         speed = {2'b00, s100};
         lmode = {4'h0, md};
         bcast = {2'b00, bc};
         acc(1'b0, 1'b1, 8'h19, {1'b0, code}, d);
         n = 0;
         bvld = 3'h1;
         for (k = 0; k < 8000; k = k + 1)
         begin
            @(negedge i_clk);
            if (accept[0] === 1'b1)
               n = n + 1;
         end
         bvld = 3'h0;
         chk_rng("accepted bytes", lo, hi, n);
         $display("test shaper code %h done", code);
      end
   endtask
   // ------------------------------------------------
   // hang guard
   // ------------------------------------------------
   always @(posedge i_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 90000)
      begin
         errors = errors + 1;
         end_of_test;
      end
   end
   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial
   begin
      do_reset;
      for (i = 0; i < 10; i = i + 1)
      begin
         acc(1'b0, 1'b0, AMAP[79-8*i -: 8], 8'h00, d);
         chk("reset value", 8'h00, d);
      end
      for (i = 0; i < 10; i = i + 1)
      begin
         if (AMAP[75-8*i -: 4] != 4'hA)
            acc(1'b0, 1'b1, AMAP[79-8*i -: 8], 8'hFF, d);
         acc(1'b0, 1'b0, AMAP[79-8*i -: 8], 8'h00, d);
         chk("written value", (AMAP[75-8*i -: 4] == 4'h9) ? 8'h7F : 8'h00, d);
      end
      $display("test register map done");
      acc(1'b0, 1'b1, 8'h1A, 8'h0E, d);
      acc(1'b0, 1'b0, 8'h1A, 8'h00, d);
      chk("port 1 control", 8'h0A, d);
      acc(1'b1, 1'b1, 8'h2A, 8'h0A, d);
      acc(1'b0, 1'b0, 8'h2A, 8'h00, d);
      chk("port 2 by management", 8'h0A, d);
      chk("link force", 8'h03, {6'h00, flink});
      chk("loopback", 8'h03, {6'h00, rloop});
      acc(1'b0, 1'b1, 8'h1A, 8'h00, d);
      acc(1'b1, 1'b1, 8'h2A, 8'h00, d);
      chk("link force and loopback off", 8'h00, {4'h0, flink, rloop});
      $display("test control bits done");
      lat = 8'd40;
      mres = 2'b01;
      mshort = 1'b1;
      mcnt = 9'h1A5;
      acc(1'b0, 1'b1, 8'h2A, 8'h10, d);
      acc(1'b0, 1'b0, 8'h2A, 8'h00, d);
      chk("test running", 8'h10, d & 8'h10);
      poll(1'b0, 8'h2A, d);
      chk("port 2 outcome", 8'hA1, d);
      acc(1'b0, 1'b0, 8'h2B, 8'h00, d);
      chk("port 2 low count", 8'hA5, d);
      lat = 8'd1;
      mres = 2'b11;
      mshort = 1'b0;
      mcnt = 9'h0FF;
      acc(1'b1, 1'b1, 8'h1A, 8'h10, d);
      poll(1'b1, 8'h1A, d);
      chk("port 1 outcome", 8'h60, d);
      acc(1'b0, 1'b0, 8'h1B, 8'h00, d);
      chk("port 1 low byte", 8'h00, d);
      $display("test cable diagnostic done");
      do_reset;
      lmode = 6'h24;
      acc(1'b0, 1'b1, 8'h29, 8'h01, d);
      acc(1'b0, 1'b1, 8'h39, 8'h01, d);
      bvld = 3'h6;
      flood = 3'h6;
      @(negedge i_clk);
      chk("accept by class", 8'h04, {5'h00, accept});
      flood = 3'h0;
      mcast = 3'h4;
      @(negedge i_clk);
      chk("accept by class", 8'h02, {5'h00, accept});
      bvld = 3'h0;
      mcast = 3'h0;
      $display("test limit modes done");
      shape(7'h00, 1'b1, 2'h0, 1'b0, 8000, 8000);
      shape(7'h64, 1'b1, 2'h0, 1'b0, 8000, 8000);
      shape(7'h01, 1'b1, 2'h0, 1'b0, 375, 500);
      shape(7'h09, 1'b0, 2'h0, 1'b0, 3375, 4500);
      shape(7'h0A, 1'b0, 2'h0, 1'b0, 8000, 8000);
      shape(7'h65, 1'b1, 2'h0, 1'b0, 24, 32);
      shape(7'h73, 1'b1, 2'h3, 1'b1, 360, 480);
      shape(7'h01, 1'b1, 2'h3, 1'b0, 8000, 8000);
      end_of_test;
   end
endmodule // tb_top
